//--- common/rcc_pkg.sv
// package for the reset and clock control unit: offsets, fields, resets
// assumes word-aligned byte addresses on a plain register port
package rcc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_FLAG    = 8'h08;
  localparam logic [7:0] ADDR_PLL_CONFIG    = 8'h18;
  localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h1C;
  localparam logic [7:0] ADDR_SYSTEM_MODE   = 8'h20;
  localparam logic [7:0] ADDR_MAIN_DIVIDER  = 8'h40;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_WAKEUP_RES   = 10;
  localparam int BIT_UNDERVOLT    = 9;
  localparam int BIT_RTC_ALARM    = 7;
  localparam int BIT_WATCHDOG     = 6;
  localparam int BIT_SOFTWARE     = 5;
  localparam int BIT_SLOW_SELECT  = 3;
  localparam int BIT_ALT_STATUS   = 2;
  localparam int BIT_PLL_LOCKED   = 1;
  localparam int BIT_PLL_SELECT   = 0;
  localparam int BIT_FREE_RUN     = 7;
  localparam int BIT_REF_RANGE    = 6;
  localparam int BIT_MUL_LO       = 4;
  localparam int BIT_HALT_ENABLE  = 11;
  localparam int BIT_SRES_ENABLE  = 3;
  localparam int BIT_ALT_SELECT   = 2;
  localparam int BIT_HALT         = 1;
  localparam int BIT_WAIT         = 0;
  localparam int BIT_EMI_CLOCK    = 2;
  localparam int BIT_USB_CLOCK    = 4;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [31:0] RESET_PERIPH_ENABLE = 32'h0001FFFF;
  localparam logic [2:0]  DIVIDE_OFF          = 3'h7;
  localparam logic [1:0]  MULTIPLY_RESET      = 2'h0;
  localparam logic [1:0]  PRESCALE_RESET      = 2'h0;

  // root clock source choice
  typedef enum logic [3:0] {
    SRC_INPUT = 4'h1,
    SRC_SLOW  = 4'h2,
    SRC_PLL   = 4'h4,
    SRC_ALT   = 4'h8
  } rcc_source_type;

  // pll settings handed to the analog macro
  typedef struct packed {
    logic       enable;
    logic       free_run;
    logic       ref_range;
    logic [4:0] multiply;
    logic [2:0] divide;
  } rcc_pll_ctrl_type;

  // causes of the last reset, latched once after release
  typedef struct packed {
    logic wakeup;
    logic undervolt;
    logic rtc_alarm;
    logic watchdog;
    logic software;
  } rcc_cause_type;

endpackage

//--- hw/rcc_prescaler.sv
// system clock prescaler: makes a one-cycle enable every 1,2,4,8 cycles
// assumes the prescale code may change at any time
`timescale 1ns/1ps
module rcc_prescaler (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [1:0] prescale,
  output logic            tick
);

  logic [2:0] count_reg;
  logic [2:0] limit;

  // terminal count from the code; 00 gives a tick every cycle
  always_comb begin
    unique case (prescale)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      2'h3: limit = 3'h7;
    endcase
  end

  // a count past a freshly lowered limit wraps at once, so no long stall
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_reg <= 3'h0;
      tick      <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= 3'h0;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 3'h1;
      tick      <= 1'b0;
    end
  end

endmodule

//--- hw/rcc_unit.sv
// reset and clock control unit: reset cause flags, root clock choice,
// pll settings, peripheral clock gates, soft reset and wait requests
// assumes inputs synchronous to mclk and a plain one-cycle register port
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module rcc_unit (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic [31:0]                    reg_rdata,
  input  rcc_pkg::rcc_cause_type         reset_cause,
  input  wire logic                      pll_locked_in,
  input  wire logic                      regulator_ok,
  input  wire logic                      crystal_stopped,
  input  wire logic                      alternate_clock_present,
  input  wire logic                      interrupt_ack,
  output rcc_pkg::rcc_source_type        clock_source,
  output rcc_pkg::rcc_pll_ctrl_type      pll_ctrl,
  output logic [31:0]                    peripheral_clock_enable_bits,
  output logic                           emi_clock_enable,
  output logic                           usb_clock_enable,
  output logic                           software_reset_req,
  output logic                           cpu_idle,
  output logic                           system_clock_tick
);

  // ****************************************************************
  // registers
  // ****************************************************************
  rcc_pkg::rcc_cause_type cause_reg;
  logic        cause_taken_reg;
  logic        slow_select_reg;
  logic        pll_select_reg;
  logic        pll_select_next;
  logic        free_running_enable_reg;
  logic        reference_range_reg;
  logic [1:0]  pll_multiply_reg;
  logic [2:0]  pll_divide_reg;
  logic [31:0] periph_reg;
  logic        wait_for_interrupt_bit_reg;
  logic        halt_enable_reg;
  logic        software_reset_enable_reg;
  logic        alternate_clock_select_reg;
  logic [1:0]  system_clock_prescale_reg;
  logic        alt_status_reg;
  logic        lock_status_reg;
  logic        wr_ctrl;
  logic        wr_flag;
  logic        wr_pll;
  logic        wr_per;
  logic        wr_smr;
  logic        wr_div;
  logic        pll_off;
  logic        pll_usable;
  logic        pll_hold_low;
  logic        tick;
  rcc_pkg::rcc_source_type source_next;
  logic [4:0]  multiply_value;
  logic [31:0] read_next;

  // ****************************************************************
  // write decode
  // ****************************************************************
  assign wr_ctrl = reg_write && (reg_addr == rcc_pkg::ADDR_CLOCK_CONTROL);
  assign wr_flag = reg_write && (reg_addr == rcc_pkg::ADDR_CLOCK_FLAG);
  assign wr_pll  = reg_write && (reg_addr == rcc_pkg::ADDR_PLL_CONFIG);
  assign wr_per  = reg_write && (reg_addr == rcc_pkg::ADDR_PERIPH_ENABLE);
  assign wr_smr  = reg_write && (reg_addr == rcc_pkg::ADDR_SYSTEM_MODE);
  assign wr_div  = reg_write && (reg_addr == rcc_pkg::ADDR_MAIN_DIVIDER);

  // ****************************************************************
  // reset cause capture
  // ****************************************************************
  // causes are sampled at the first edge after release, never under reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cause_reg       <= '0;
      cause_taken_reg <= 1'b0;
    end else if (!cause_taken_reg) begin
      cause_reg       <= reset_cause;
      cause_taken_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // pll status
  // ****************************************************************
  // divide 111 with free-run off stops the pll entirely
  assign pll_off = ((pll_divide_reg == rcc_pkg::DIVIDE_OFF) &&
                   !free_running_enable_reg) || !slow_select_reg;
  // free-run ignores lock and regulator; otherwise both are needed
  assign pll_usable = free_running_enable_reg ||
                      (pll_locked_in && regulator_ok && !pll_off);
  // hardware keeps the select low in these cases
  assign pll_hold_low = (pll_divide_reg == rcc_pkg::DIVIDE_OFF &&
                         !free_running_enable_reg) ||
                        crystal_stopped || !slow_select_reg;

  // lock flag reads 0 whenever the pll is off
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lock_status_reg <= 1'b0;
    end else begin
      lock_status_reg <= pll_locked_in && !pll_off;
    end
  end

  // ****************************************************************
  // clock flag register bits
  // ****************************************************************
  // a free-run backup at divide 111 still counts as a usable pll
  always_comb begin
    pll_select_next = pll_select_reg;
    if (wr_flag) begin
      pll_select_next = reg_wdata[rcc_pkg::BIT_PLL_SELECT];
    end
    if (pll_hold_low) begin
      pll_select_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slow_select_reg <= 1'b1;
      pll_select_reg  <= 1'b0;
    end else begin
      if (wr_flag) begin
        slow_select_reg <= reg_wdata[rcc_pkg::BIT_SLOW_SELECT];
      end
      pll_select_reg <= pll_select_next;
    end
  end

  // ****************************************************************
  // pll configuration register
  // ****************************************************************
  // multiply changes are taken as written; safe ordering is software's job
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      free_running_enable_reg <= 1'b0;
      reference_range_reg     <= 1'b0;
      pll_multiply_reg        <= rcc_pkg::MULTIPLY_RESET;
      pll_divide_reg          <= rcc_pkg::DIVIDE_OFF;
    end else if (wr_pll) begin
      free_running_enable_reg <= reg_wdata[rcc_pkg::BIT_FREE_RUN];
      reference_range_reg     <= reg_wdata[rcc_pkg::BIT_REF_RANGE];
      pll_multiply_reg        <= reg_wdata[rcc_pkg::BIT_MUL_LO +: 2];
      pll_divide_reg          <= reg_wdata[2:0];
    end
  end

  // multiply code to factor
  always_comb begin
    unique case (pll_multiply_reg)
      2'h2: multiply_value = 5'h18;
      2'h0: multiply_value = 5'h14;
      2'h3: multiply_value = 5'h10;
      2'h1: multiply_value = 5'h0C;
    endcase
  end

  // settings to the analog pll; divide code plus one is the ratio
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pll_ctrl <= '0;
    end else begin
      pll_ctrl.enable    <= !pll_off;
      pll_ctrl.free_run  <= free_running_enable_reg && !pll_off &&
                            (pll_divide_reg == rcc_pkg::DIVIDE_OFF);
      pll_ctrl.ref_range <= reference_range_reg;
      pll_ctrl.multiply  <= multiply_value;
      pll_ctrl.divide    <= pll_divide_reg;
    end
  end

  // ****************************************************************
  // clock control register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      halt_enable_reg            <= 1'b0;
      software_reset_enable_reg  <= 1'b0;
      alternate_clock_select_reg <= 1'b0;
    end else if (wr_ctrl) begin
      halt_enable_reg            <= reg_wdata[rcc_pkg::BIT_HALT_ENABLE];
      software_reset_enable_reg  <= reg_wdata[rcc_pkg::BIT_SRES_ENABLE];
      alternate_clock_select_reg <= reg_wdata[rcc_pkg::BIT_ALT_SELECT];
    end
  end

  // ****************************************************************
  // root clock selection
  // ****************************************************************
  // alternate only takes effect when that clock actually exists
  always_comb begin
    if (alternate_clock_select_reg && alternate_clock_present) begin
      source_next = rcc_pkg::SRC_ALT;
    end else if (!slow_select_reg) begin
      source_next = rcc_pkg::SRC_SLOW;
    end else if (pll_select_reg && pll_usable) begin
      source_next = rcc_pkg::SRC_PLL;
    end else begin
      source_next = rcc_pkg::SRC_INPUT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clock_source   <= rcc_pkg::SRC_INPUT;
      alt_status_reg <= 1'b0;
    end else begin
      clock_source   <= source_next;
      alt_status_reg <= (source_next == rcc_pkg::SRC_ALT);
    end
  end

  // ****************************************************************
  // peripheral clock gates
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      periph_reg <= rcc_pkg::RESET_PERIPH_ENABLE;
    end else if (wr_per) begin
      periph_reg <= reg_wdata;
    end
  end

  // gate outputs mirror the register one cycle later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      peripheral_clock_enable_bits <= rcc_pkg::RESET_PERIPH_ENABLE;
      emi_clock_enable             <= 1'b1;
      usb_clock_enable             <= 1'b1;
    end else begin
      peripheral_clock_enable_bits <= periph_reg;
      emi_clock_enable <= periph_reg[rcc_pkg::BIT_EMI_CLOCK];
      usb_clock_enable <= periph_reg[rcc_pkg::BIT_USB_CLOCK];
    end
  end

  // ****************************************************************
  // system mode: halt and wait
  // ****************************************************************
  // halt is not stored; it is a one-cycle reset request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      software_reset_req <= 1'b0;
    end else begin
      software_reset_req <= wr_smr && reg_wdata[rcc_pkg::BIT_HALT] &&
                            software_reset_enable_reg &&
                            halt_enable_reg;
    end
  end

  // acknowledge wins over a clear in the same cycle; writing 1 does nothing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_for_interrupt_bit_reg <= 1'b1;
    end else if (interrupt_ack) begin
      wait_for_interrupt_bit_reg <= 1'b1;
    end else if (wr_smr && !reg_wdata[rcc_pkg::BIT_WAIT]) begin
      wait_for_interrupt_bit_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpu_idle <= 1'b0;
    end else begin
      cpu_idle <= !wait_for_interrupt_bit_reg && !interrupt_ack;
    end
  end

  // ****************************************************************
  // main clock prescale
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      system_clock_prescale_reg <= rcc_pkg::PRESCALE_RESET;
    end else if (wr_div) begin
      system_clock_prescale_reg <= reg_wdata[1:0];
    end
  end

  rcc_prescaler i_rcc_prescaler (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .prescale (system_clock_prescale_reg),
    .tick     (tick)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      system_clock_tick <= 1'b0;
    end else begin
      system_clock_tick <= tick;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped addresses read zero
  always_comb begin
    read_next = 32'h0;
    unique case (reg_addr)
      rcc_pkg::ADDR_CLOCK_CONTROL: begin
        read_next[rcc_pkg::BIT_HALT_ENABLE] = halt_enable_reg;
        read_next[rcc_pkg::BIT_SRES_ENABLE] = software_reset_enable_reg;
        read_next[rcc_pkg::BIT_ALT_SELECT]  = alternate_clock_select_reg;
      end
      rcc_pkg::ADDR_CLOCK_FLAG: begin
        read_next[rcc_pkg::BIT_WAKEUP_RES]  = cause_reg.wakeup;
        read_next[rcc_pkg::BIT_UNDERVOLT]   = cause_reg.undervolt;
        read_next[rcc_pkg::BIT_RTC_ALARM]   = cause_reg.rtc_alarm;
        read_next[rcc_pkg::BIT_WATCHDOG]    = cause_reg.watchdog;
        read_next[rcc_pkg::BIT_SOFTWARE]    = cause_reg.software;
        read_next[rcc_pkg::BIT_SLOW_SELECT] = slow_select_reg;
        read_next[rcc_pkg::BIT_ALT_STATUS]  = alt_status_reg;
        read_next[rcc_pkg::BIT_PLL_LOCKED]  = lock_status_reg;
        read_next[rcc_pkg::BIT_PLL_SELECT]  = pll_select_reg;
      end
      rcc_pkg::ADDR_PLL_CONFIG: begin
        read_next[7:0] = {free_running_enable_reg, reference_range_reg,
                          pll_multiply_reg, 1'b0, pll_divide_reg};
      end
      rcc_pkg::ADDR_PERIPH_ENABLE: read_next = periph_reg;
      rcc_pkg::ADDR_SYSTEM_MODE: begin
        read_next[rcc_pkg::BIT_WAIT] = wait_for_interrupt_bit_reg;
      end
      rcc_pkg::ADDR_MAIN_DIVIDER: begin
        read_next[1:0] = system_clock_prescale_reg;
      end
      default: read_next = 32'h0;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      reg_rdata <= read_next;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule

//--- tb/rcc_unit_assertions.sv
// port checker for the reset and clock control unit
// assumes one mclk domain, bound to rcc_unit from the bench top file
`timescale 1ns/1ps
module rcc_unit_assertions (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic [7:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic [31:0]          reg_rdata,
  input rcc_pkg::rcc_cause_type    reset_cause,
  input wire logic                 pll_locked_in,
  input wire logic                 regulator_ok,
  input wire logic                 crystal_stopped,
  input wire logic                 alternate_clock_present,
  input wire logic                 interrupt_ack,
  input rcc_pkg::rcc_source_type   clock_source,
  input rcc_pkg::rcc_pll_ctrl_type pll_ctrl,
  input wire logic [31:0]          peripheral_clock_enable_bits,
  input wire logic                 emi_clock_enable,
  input wire logic                 usb_clock_enable,
  input wire logic                 software_reset_req,
  input wire logic                 cpu_idle,
  input wire logic                 system_clock_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // sequences and properties
  // ****************************************************************
  // factor table of the multiply code
  function automatic logic [4:0] mul_f(input logic [1:0] c);
    case (c)
      2'h2: mul_f = 5'h18;
      2'h0: mul_f = 5'h14;
      2'h3: mul_f = 5'h10;
      default: mul_f = 5'h0C;
    endcase
  endfunction
  sequence s_mode_wr;
    reg_write && reg_addr == rcc_pkg::ADDR_SYSTEM_MODE;
  endsequence
  sequence s_slow_wr;
    reg_write && reg_addr == rcc_pkg::ADDR_CLOCK_FLAG && !reg_wdata[3]
      ##1 !alternate_clock_present;
  endsequence
  property p_gates;
    emi_clock_enable == peripheral_clock_enable_bits[2] &&
      usb_clock_enable == peripheral_clock_enable_bits[4];
  endproperty
  property p_halt;
    software_reset_req |->
      $past(reg_write && reg_addr == 8'h20 && reg_wdata[1]);
  endproperty
  property p_wait;
    s_mode_wr and (!reg_wdata[0] && !interrupt_ack) |-> ##2 cpu_idle;
  endproperty
  property p_ack;
    interrupt_ack |-> ##2 !cpu_idle;
  endproperty
  property p_pll_off;
    pll_ctrl.divide == 3'h7 |-> pll_ctrl.enable == pll_ctrl.free_run;
  endproperty
  property p_pll_fields;
    $past(reg_write && reg_addr == 8'h18, 2) |->
      pll_ctrl.multiply == mul_f($past(reg_wdata[5:4], 2)) &&
      pll_ctrl.divide == $past(reg_wdata[2:0], 2);
  endproperty
  property p_slow;
    s_slow_wr |=> clock_source == rcc_pkg::SRC_SLOW;
  endproperty
  property p_crystal;
    $past(crystal_stopped) && $past(crystal_stopped, 2) |->
      clock_source != rcc_pkg::SRC_PLL;
  endproperty
  // slowest prescale gives a tick every 8 cycles, never longer
  property p_tick;
    $fell(system_clock_tick) |-> ##[1:7] system_clock_tick;
  endproperty

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_gates: assert property (p_gates)
    else $error("gate outputs differ from enable bits");
  a_halt: assert property (p_halt)
    else $error("soft reset without halt write");
  a_wait: assert property (p_wait)
    else $error("cpu not idle after wait clear");
  a_ack: assert property (p_ack)
    else $error("cpu still idle after acknowledge");
  a_pll_off: assert property (p_pll_off)
    else $error("pll enable wrong for divide 7");
  a_pll_fields: assert property (p_pll_fields)
    else $error("pll multiply or divide wrong");
  a_slow: assert property (p_slow)
    else $error("slow clock not chosen");
  a_crystal: assert property (p_crystal)
    else $error("pll chosen with crystal stopped");
  a_tick: assert property (p_tick)
    else $error("tick gap too long");
endmodule

//--- tb/rcc_unit_test.sv
// self-checking bench for the reset and clock control unit
// assumes rcc_pkg compiled first; the bench drives every port itself
`timescale 1ns/1ps
module rcc_unit_test;
  logic mclk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, periph, d, ticks = 32'h0;
  logic [31:0] errors = 32'h0, tests_run = 32'h0, cycles = 32'h0;
  logic [31:0] reqs = 32'h0;
  logic pll_locked_in = 1'b0, regulator_ok = 1'b1, crystal_stopped = 1'b0;
  logic alternate_clock_present = 1'b0, interrupt_ack = 1'b0;
  logic emi_clock_enable, usb_clock_enable, software_reset_req, cpu_idle;
  logic system_clock_tick;
  rcc_pkg::rcc_cause_type    reset_cause = 5'h0;
  rcc_pkg::rcc_source_type   clock_source;
  rcc_pkg::rcc_pll_ctrl_type pll_ctrl;

  rcc_unit i_rcc_unit (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reset_cause(reset_cause),
    .pll_locked_in(pll_locked_in), .regulator_ok(regulator_ok),
    .crystal_stopped(crystal_stopped),
    .alternate_clock_present(alternate_clock_present),
    .interrupt_ack(interrupt_ack), .clock_source(clock_source),
    .pll_ctrl(pll_ctrl), .peripheral_clock_enable_bits(periph),
    .emi_clock_enable(emi_clock_enable),
    .usb_clock_enable(usb_clock_enable),
    .software_reset_req(software_reset_req), .cpu_idle(cpu_idle),
    .system_clock_tick(system_clock_tick));

  // ****************************************************************
  // clock, event counters, hang guard
  // ****************************************************************
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (system_clock_tick === 1'b1) ticks <= ticks + 1;
    if (software_reset_req === 1'b1) reqs <= reqs + 1;
    if (cycles == 32'h4E20) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  // ****************************************************************
  // bus tasks and comparison
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the read strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // flag register image: latched causes plus the low status bits
  function automatic logic [31:0] fl(input logic [3:0] low);
    fl = {21'h0, reset_cause.wakeup, reset_cause.undervolt, 1'b0,
          reset_cause.rtc_alarm, reset_cause.watchdog,
          reset_cause.software, 1'b0, low};
  endfunction
  function automatic logic [4:0] mul(input logic [1:0] c);
    mul = (c == 2'h2) ? 5'h18 : (c == 2'h0) ? 5'h14 :
          (c == 2'h3) ? 5'h10 : 5'h0C;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(27273));
    reset_cause = 5'($urandom);
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    settle(2);
    // reset values, read-only bits, unmapped place
    chk("periph out", periph, 32'h0001FFFF);
    rc(8'h08, fl(4'h8));
    wr(8'h08, 32'hFFFFFFFE);
    rc(8'h08, fl(4'h8));
    rc(8'h18, 32'h7);
    rc(8'h20, 32'h1);
    rc(8'h40, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rc(8'h3C, 32'h0);
    $display("test reset done");
    // pll fields for every multiply code
    for (int c = 0; c < 4; c++) begin
      if (c > 0) wr(8'h18, d | 32'h7);
      d = {25'h0, 1'($urandom), 2'(c), 1'b0, 3'($urandom_range(6))};
      wr(8'h18, d);
      settle(2);
      chk("multiply", {27'h0, pll_ctrl.multiply}, {27'h0, mul(d[5:4])});
      chk("divide", {29'h0, pll_ctrl.divide}, {29'h0, d[2:0]});
      chk("range", {31'h0, pll_ctrl.ref_range}, {31'h0, d[6]});
      rc(8'h18, d);
    end
    $display("test pll fields done");
    // root clock choice
    pll_locked_in <= 1'b1;
    wr(8'h08, 32'h9);
    settle(3);
    chk("src pll", 32'(clock_source), 32'(rcc_pkg::SRC_PLL));
    rc(8'h08, fl(4'hB));
    regulator_ok <= 1'b0;
    settle(3);
    chk("src noreg", 32'(clock_source), 32'(rcc_pkg::SRC_INPUT));
    pll_locked_in <= 1'b0;
    wr(8'h18, 32'hB7);
    settle(3);
    chk("src free", 32'(clock_source), 32'(rcc_pkg::SRC_PLL));
    chk("pll on", {31'h0, pll_ctrl.enable}, 32'h1);
    crystal_stopped <= 1'b1;
    settle(3);
    crystal_stopped <= 1'b0;
    chk("src xtal", 32'(clock_source), 32'(rcc_pkg::SRC_INPUT));
    rc(8'h08, fl(4'h8));
    wr(8'h18, 32'h37);
    wr(8'h08, 32'h9);
    settle(3);
    chk("pll off", {31'h0, pll_ctrl.enable}, 32'h0);
    chk("src off", 32'(clock_source), 32'(rcc_pkg::SRC_INPUT));
    rc(8'h08, fl(4'h8));
    wr(8'h18, 32'h0);
    wr(8'h08, 32'h1);
    settle(3);
    chk("src slow", 32'(clock_source), 32'(rcc_pkg::SRC_SLOW));
    chk("slowoff", {31'h0, pll_ctrl.enable}, 32'h0);
    rc(8'h08, fl(4'h0));
    alternate_clock_present <= 1'b1;
    wr(8'h00, 32'h4);
    settle(3);
    chk("src alt", 32'(clock_source), 32'(rcc_pkg::SRC_ALT));
    rc(8'h08, fl(4'h4));
    wr(8'h00, 32'h0);
    $display("test clock choice done");
    // peripheral gates, zero corner then random
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'h0 : $urandom;
      wr(8'h1C, d);
      settle(2);
      chk("periph", periph, d);
      chk("gates", {30'h0, usb_clock_enable, emi_clock_enable},
          {30'h0, d[4], d[2]});
      rc(8'h1C, d);
    end
    $display("test gates done");
    // halt needs both enables
    d = reqs;
    wr(8'h20, 32'h3);
    wr(8'h00, 32'h8);
    wr(8'h20, 32'h3);
    settle(3);
    chk("no reset", reqs - d, 32'h0);
    wr(8'h00, 32'h808);
    wr(8'h20, 32'h3);
    settle(3);
    chk("reset req", reqs - d, 32'h1);
    rc(8'h20, 32'h1);
    $display("test halt done");
    // wait entry, ignored set, acknowledge
    wr(8'h20, 32'h0);
    wr(8'h20, 32'h1);
    settle(2);
    chk("idle", {31'h0, cpu_idle}, 32'h1);
    rc(8'h20, 32'h0);
    @(posedge mclk);
    interrupt_ack <= 1'b1;
    @(posedge mclk);
    interrupt_ack <= 1'b0;
    settle(3);
    chk("awake", {31'h0, cpu_idle}, 32'h0);
    rc(8'h20, 32'h1);
    $display("test wait done");
    // prescale ratios 1,2,4,8 over 16 cycles
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, 32'hFFFC | 32'(c));
      settle(10);
      d = ticks;
      settle(16);
      chk("ticks", ticks - d, 32'h10 >> c);
      rc(8'h40, 32'(c));
    end
    $display("test prescale done");
    report_and_stop();
  end
endmodule

bind rcc_unit rcc_unit_assertions i_rcc_unit_assertions (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .reset_cause(reset_cause),
  .pll_locked_in(pll_locked_in), .regulator_ok(regulator_ok),
  .crystal_stopped(crystal_stopped),
  .alternate_clock_present(alternate_clock_present),
  .interrupt_ack(interrupt_ack), .clock_source(clock_source),
  .pll_ctrl(pll_ctrl),
  .peripheral_clock_enable_bits(peripheral_clock_enable_bits),
  .emi_clock_enable(emi_clock_enable),
  .usb_clock_enable(usb_clock_enable),
  .software_reset_req(software_reset_req), .cpu_idle(cpu_idle),
  .system_clock_tick(system_clock_tick));
